/* rtl/clcc_pkg.sv */
// package: register map, fields and constants of the configurable logic cell
// Notes on behaviour
// - cell output is forced low whenever the cell is disabled
// - enabled cell combines selected inputs through gates and chosen function
// - read-only output status bit shows cell output after output inversion
// - rising output edge sets interrupt flag only when rising enable is set
// - falling output edge sets interrupt flag only when falling enable is set
// - function 000 is AND-OR, 001 is OR-XOR, 010 is four-input AND
// - function 011 is a set-reset latch driven by gate outputs
// - function 100 is D flip-flop with set and reset from gates
// - function 101 is two-data-input D flip-flop with reset
// - function 110 is J-K flip-flop with reset
// - function 111 is transparent latch with set and reset
// - output invert flips function result before it reaches the output
// - each gate has its own invert bit, gate 0 lowest
// - four six-bit source selects sit in low bits of own registers
// - unimplemented register bits read back as zero
// - control and output invert reset to zero; gate setup is kept
// - every reset clears control but leaves selection and gating alone
// - uninverted gate combines enabled inputs; inverted forms give the AND
`default_nettype none
package clcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SEL_W = 6;
  localparam int NUM_DATA = 4;
  localparam int NUM_GATES = 4;
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_SELECT0 = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_GATE_SEL0 = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG = 4'hA;
  // field positions
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_RISE_BIT = 4;
  localparam int CTL_FALL_BIT = 3;
  localparam int POL_OUT_BIT = 7;
  localparam int IRQ_FLAG_BIT = 0;
  // values after reset
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic OUT_INVERT_RESET = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  typedef logic [2:0] clcc_mode_t;
  localparam clcc_mode_t MODE_AND_OR = 3'h0;
  localparam clcc_mode_t MODE_OR_XOR = 3'h1;
  localparam clcc_mode_t MODE_AND4 = 3'h2;
  localparam clcc_mode_t MODE_SR_LATCH = 3'h3;
  localparam clcc_mode_t MODE_DFF_SR = 3'h4;
  localparam clcc_mode_t MODE_DFF_2IN = 3'h5;
  localparam clcc_mode_t MODE_JK = 3'h6;
  localparam clcc_mode_t MODE_LATCH_SR = 3'h7;
  typedef struct packed {
    logic cell_enable;
    logic rise_irq_enable;
    logic fall_irq_enable;
    clcc_mode_t logic_function_select;
  } clcc_ctrl_s;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } clcc_bus_s;
endpackage : clcc_pkg
`default_nettype wire

/* rtl/clcc_func.sv */
// logic function stage: combinational gates, latches and flip-flops of the cell
`default_nettype none
module clcc_func
  import clcc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic enable_in,
  input wire clcc_mode_t mode_in,
  // gate outputs after gate inversion
  input wire logic [NUM_GATES-1:0] gates_in,
  // function result, before output inversion
  output logic result_out
);
  logic seq_q_r;
  logic seq_nxt;
  logic clk_prev_r;
  logic clk_rise;
  logic comb_res;

  // the flip-flop clock is gate 0, sampled; its edge takes effect in the cycle gate 0 first reads high
  always_comb begin
    seq_nxt = seq_q_r;
    clk_rise = gates_in[0] & ~clk_prev_r;
    comb_res = 1'h0;
    unique case (mode_in)
      MODE_AND_OR: comb_res = (gates_in[0] & gates_in[1]) | (gates_in[2] & gates_in[3]);
      MODE_OR_XOR: comb_res = (gates_in[0] | gates_in[1]) ^ (gates_in[2] | gates_in[3]);
      MODE_AND4: comb_res = &gates_in;
      MODE_SR_LATCH: begin
        if (gates_in[0] | gates_in[1]) seq_nxt = 1'h1;
        else if (gates_in[2] | gates_in[3]) seq_nxt = 1'h0;
      end
      MODE_DFF_SR: begin
        if (gates_in[2]) seq_nxt = 1'h0;
        else if (gates_in[3]) seq_nxt = 1'h1;
        else if (clk_rise) seq_nxt = gates_in[1];
      end
      MODE_DFF_2IN: begin
        if (gates_in[2]) seq_nxt = 1'h0;
        else if (clk_rise) seq_nxt = gates_in[1] & gates_in[3];
      end
      MODE_JK: begin
        if (gates_in[2]) seq_nxt = 1'h0;
        else if (clk_rise) begin
          unique case ({gates_in[1], gates_in[3]})
            2'h0: seq_nxt = seq_q_r;
            2'h1: seq_nxt = 1'h0;
            2'h2: seq_nxt = 1'h1;
            2'h3: seq_nxt = ~seq_q_r;
          endcase
        end
      end
      MODE_LATCH_SR: begin
        if (gates_in[2]) seq_nxt = 1'h0;
        else if (gates_in[3]) seq_nxt = 1'h1;
        else if (gates_in[0]) seq_nxt = gates_in[1];
      end
    endcase
    // a disabled cell restarts its storage from zero
    if (!enable_in) seq_nxt = 1'h0;
    result_out = (mode_in <= MODE_AND4) ? comb_res : seq_nxt;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      seq_q_r <= 1'h0;
      clk_prev_r <= 1'h0;
    end else begin
      seq_q_r <= seq_nxt;
      clk_prev_r <= gates_in[0];
    end
  end

  property p_sr_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    enable_in && mode_in == MODE_SR_LATCH && gates_in == 4'h0 && $past(enable_in) && $past(mode_in) == MODE_SR_LATCH
    |-> result_out == $past(result_out);
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("latch did not hold");

  property p_dff2_capture;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    enable_in && mode_in == MODE_DFF_2IN && !gates_in[2] && gates_in[0] && !$past(gates_in[0])
    |-> result_out == (gates_in[1] & gates_in[3]);
  endproperty
  a_dff2_capture: assert property (p_dff2_capture) else $error("flip-flop missed data");

  property p_dffsr_reset;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    enable_in && mode_in == MODE_DFF_SR && gates_in[2] |-> !result_out;
  endproperty
  a_dffsr_reset: assert property (p_dffsr_reset) else $error("reset input ignored");
endmodule : clcc_func
`default_nettype wire

/* rtl/clcc_top.sv */
// configurable logic cell: registers, input selection, gating, output and edge flag
`default_nettype none
module clcc_top
  import clcc_pkg::*;
#(
  parameter int NUM_SRC = 2 ** SEL_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // selectable sources
  input wire logic [NUM_SRC-1:0] cell_inputs_in,
  // cell results
  output logic cell_output_out,
  output logic cell_irq_flag_out
);
  clcc_bus_s bus;
  clcc_ctrl_s ctrl_r;
  clcc_ctrl_s ctrl_nxt;
  logic output_invert_r;
  logic output_invert_nxt;
  logic [NUM_GATES-1:0] gate_invert_r;
  logic [NUM_GATES-1:0] gate_invert_nxt;
  logic [SEL_W-1:0] data_source_r [NUM_DATA];
  logic [SEL_W-1:0] data_source_nxt [NUM_DATA];
  logic [DATA_W-1:0] gate_sel_r [NUM_GATES];
  logic [DATA_W-1:0] gate_sel_nxt [NUM_GATES];
  logic cell_output_r;
  logic cell_output_nxt;
  logic irq_flag_r;
  logic irq_flag_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [NUM_DATA-1:0] data_sel;
  logic [NUM_GATES-1:0] gate_out;
  logic func_res;
  logic rise_evt;
  logic fall_evt;
  logic flag_clear;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : addr_hit

  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // input selection and data gating
  generate
    for (genvar d = 0; d < NUM_DATA; d++) begin : g_data
      // out-of-range selections read as zero rather than wrapping
      assign data_sel[d] = (32'(data_source_r[d]) < NUM_SRC) ? cell_inputs_in[data_source_r[d]] : 1'h0;
    end
    for (genvar g = 0; g < NUM_GATES; g++) begin : g_gate
      logic [NUM_DATA-1:0] terms;
      for (genvar d = 0; d < NUM_DATA; d++) begin : g_term
        assign terms[d] = (data_sel[d] & gate_sel_r[g][2*d+1]) | (~data_sel[d] & gate_sel_r[g][2*d]);
      end
      // negated inputs with an inverted gate give the AND of the enabled data
      assign gate_out[g] = (|terms) ^ gate_invert_r[g];
    end
  endgenerate

  clcc_func u_func (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(ctrl_r.cell_enable),
    .mode_in(ctrl_r.logic_function_select),
    .gates_in(gate_out),
    .result_out(func_res)
  );

  // register writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    output_invert_nxt = output_invert_r;
    gate_invert_nxt = gate_invert_r;
    data_source_nxt = data_source_r;
    gate_sel_nxt = gate_sel_r;
    if (bus.wr) begin
      if (addr_hit(bus.addr, OFF_CONTROL)) begin
        // the status bit position is not stored anywhere, so a write to it has no effect
        ctrl_nxt.cell_enable = bus.wdata[CTL_ENABLE_BIT];
        ctrl_nxt.rise_irq_enable = bus.wdata[CTL_RISE_BIT];
        ctrl_nxt.fall_irq_enable = bus.wdata[CTL_FALL_BIT];
        ctrl_nxt.logic_function_select = bus.wdata[2:0];
      end
      if (addr_hit(bus.addr, OFF_POLARITY)) begin
        output_invert_nxt = bus.wdata[POL_OUT_BIT];
        gate_invert_nxt = bus.wdata[NUM_GATES-1:0];
      end
      for (int i = 0; i < NUM_DATA; i++) begin
        if (addr_hit(bus.addr, ADDR_W'(OFF_SELECT0 + ADDR_W'(i)))) begin
          data_source_nxt[i] = bus.wdata[SEL_W-1:0];
        end
      end
      for (int i = 0; i < NUM_GATES; i++) begin
        if (addr_hit(bus.addr, ADDR_W'(OFF_GATE_SEL0 + ADDR_W'(i)))) begin
          gate_sel_nxt[i] = bus.wdata;
        end
      end
    end
  end

  // control and output invert clear on every reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_r <= clcc_ctrl_s'(CONTROL_RESET[5:0]);
      output_invert_r <= OUT_INVERT_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      output_invert_r <= output_invert_nxt;
    end
  end

  // selection and gating survive reset; their power-on value is undefined
  always_ff @(posedge sys_clk_in) begin
    gate_invert_r <= gate_invert_nxt;
    data_source_r <= data_source_nxt;
    gate_sel_r <= gate_sel_nxt;
  end

  // output stage and edge flag
  always_comb begin
    cell_output_nxt = ctrl_r.cell_enable ? (func_res ^ output_invert_r) : 1'h0;
    rise_evt = ctrl_r.rise_irq_enable & cell_output_nxt & ~cell_output_r;
    fall_evt = ctrl_r.fall_irq_enable & ~cell_output_nxt & cell_output_r;
    flag_clear = bus.wr & addr_hit(bus.addr, OFF_IRQ_FLAG) & bus.wdata[IRQ_FLAG_BIT];
    irq_flag_nxt = irq_flag_r;
    if (flag_clear) irq_flag_nxt = 1'h0;
    // an edge in the clearing cycle wins
    if (rise_evt | fall_evt) irq_flag_nxt = 1'h1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cell_output_r <= 1'h0;
      irq_flag_r <= 1'h0;
    end else begin
      cell_output_r <= cell_output_nxt;
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = RDATA_RESET;
    if (bus.rd) begin
      if (addr_hit(bus.addr, OFF_CONTROL)) begin
        rdata_nxt[CTL_ENABLE_BIT] = ctrl_r.cell_enable;
        rdata_nxt[CTL_OUT_BIT] = cell_output_r;
        rdata_nxt[CTL_RISE_BIT] = ctrl_r.rise_irq_enable;
        rdata_nxt[CTL_FALL_BIT] = ctrl_r.fall_irq_enable;
        rdata_nxt[2:0] = ctrl_r.logic_function_select;
      end
      if (addr_hit(bus.addr, OFF_POLARITY)) begin
        rdata_nxt[POL_OUT_BIT] = output_invert_r;
        rdata_nxt[NUM_GATES-1:0] = gate_invert_r;
      end
      for (int i = 0; i < NUM_DATA; i++) begin
        if (addr_hit(bus.addr, ADDR_W'(OFF_SELECT0 + ADDR_W'(i)))) begin
          rdata_nxt[SEL_W-1:0] = data_source_r[i];
        end
      end
      for (int i = 0; i < NUM_GATES; i++) begin
        if (addr_hit(bus.addr, ADDR_W'(OFF_GATE_SEL0 + ADDR_W'(i)))) begin
          rdata_nxt = gate_sel_r[i];
        end
      end
      if (addr_hit(bus.addr, OFF_IRQ_FLAG)) begin
        rdata_nxt[IRQ_FLAG_BIT] = irq_flag_r;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_r <= RDATA_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign cell_output_out = cell_output_r;
  assign cell_irq_flag_out = irq_flag_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_disabled_low;
    !ctrl_r.cell_enable |=> !cell_output_r;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled cell drove a one");

  property p_enabled_follow;
    ctrl_r.cell_enable |=> cell_output_r == ($past(func_res) ^ $past(output_invert_r));
  endproperty
  a_enabled_follow: assert property (p_enabled_follow) else $error("output not function result");

  property p_status_read;
    bus.rd && bus.addr == OFF_CONTROL |=> rdata_r[CTL_OUT_BIT] == $past(cell_output_r) && !rdata_r[6];
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bit wrong");

  property p_rise_sets;
    ctrl_r.rise_irq_enable && !cell_output_r ##1 cell_output_r |-> irq_flag_r;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_fall_sets;
    ctrl_r.fall_irq_enable && cell_output_r ##1 !cell_output_r |-> irq_flag_r;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_flag_cause;
    !irq_flag_r ##1 irq_flag_r |-> $past(rise_evt) || $past(fall_evt);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without enabled edge");

  property p_set_wins;
    (rise_evt || fall_evt) && flag_clear |=> irq_flag_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost during clear");

  property p_select_zero;
    bus.rd && bus.addr >= OFF_SELECT0 && bus.addr < OFF_GATE_SEL0 |=> rdata_r[7:6] == 2'h0;
  endproperty
  a_select_zero: assert property (p_select_zero) else $error("select upper bits not zero");

  property p_pol_zero;
    bus.rd && bus.addr == OFF_POLARITY |=> rdata_r[6:4] == 3'h0 && rdata_r[7] == $past(output_invert_r);
  endproperty
  a_pol_zero: assert property (p_pol_zero) else $error("polarity read wrong");

  property p_reset_clear;
    $rose(rst_n_in) |-> ctrl_r == clcc_ctrl_s'(CONTROL_RESET[5:0]) && !output_invert_r;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset");

  property p_ctrl_write;
    bus.wr && bus.addr == OFF_CONTROL |=> ctrl_r.logic_function_select == $past(bus.wdata[2:0])
      && ctrl_r.cell_enable == $past(bus.wdata[CTL_ENABLE_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_gate_const;
    gate_sel_r[0] == 8'h00 |-> gate_out[0] == gate_invert_r[0];
  endproperty
  a_gate_const: assert property (p_gate_const) else $error("empty gate not at invert level");

  // the flag is sticky: only a clear with no coinciding edge drops it
  property p_flag_hold;
    irq_flag_r && !flag_clear |=> irq_flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_clear_works;
    flag_clear && !rise_evt && !fall_evt |=> !irq_flag_r;
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("flag clear ignored");

  property p_no_enable_no_flag;
    !ctrl_r.rise_irq_enable && !ctrl_r.fall_irq_enable && !irq_flag_r |=> !irq_flag_r;
  endproperty
  a_no_enable_no_flag: assert property (p_no_enable_no_flag) else $error("flag set with edges disabled");

  // read data must return to zero so a stale value is never mistaken for a read
  property p_rdata_idle;
    !bus.rd |=> rdata_r == RDATA_RESET;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  property p_select_write;
    bus.wr && bus.addr == OFF_SELECT0 |=> data_source_r[0] == $past(bus.wdata[SEL_W-1:0]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("source select not stored");

  property p_pol_write;
    bus.wr && bus.addr == OFF_POLARITY |=> gate_invert_r == $past(bus.wdata[NUM_GATES-1:0])
      && output_invert_r == $past(bus.wdata[POL_OUT_BIT]);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write not stored");
endmodule : clcc_top
`default_nettype wire

/* verification/clcc_src_model.sv */
// source model: peripheral and pin levels feeding the cell's selectable inputs
`default_nettype none
module clcc_src_model #(
  parameter int NUM_SRC = 64,
  parameter logic [23:0] CODES = 24'h000000
) (
  // clock
  input wire logic sys_clk_in,
  // levels for the four chosen sources
  input wire logic [3:0] data_in,
  // all sources
  output logic [NUM_SRC-1:0] src_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_SRC-1:0] noise_r = '0;
  // unselected sources keep moving so a wrong select cannot pass by luck
  always @(posedge sys_clk_in) begin
    noise_r <= {noise_r[NUM_SRC-2:0], ~noise_r[NUM_SRC-1]};
  end
  always_comb begin
    src_out = noise_r;
    for (int d = 0; d < 4; d++) begin
      src_out[CODES[6*d +: 6]] = data_in[d];
    end
  end
endmodule : clcc_src_model
`default_nettype wire

/* verification/clcc_top_tb.sv */
// testbench: registers, logic functions, polarity, edge flag and reset of the cell
`default_nettype none
module clcc_top_tb import clcc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // source codes 0x01, 0x15, 0x2A and the top code 0x3F for data 0..3
  localparam logic [23:0] CODES = 24'hFEA541;
  localparam logic [7:0] SEQ [0:27] = '{8'h63, 8'h61, 8'h68, 8'h65, 8'h6B, 8'h84, 8'h87, 8'h85, 8'h8C, 8'h95,
    8'h98, 8'hB4, 8'hB7, 8'hB5, 8'hA6, 8'hC4, 8'hC7, 8'hD5, 8'hD6, 8'hD4, 8'hD7, 8'hC8, 8'hE7, 8'hE5, 8'hE1,
    8'hE2, 8'hF1, 8'hE8};
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in = 4'h0;
  logic [DATA_W-1:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic [63:0] cell_inputs;
  logic cell_output_out;
  logic cell_irq_flag_out;
  logic [3:0] data_r = 4'h0;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int prev_m = -1;
  logic [7:0] pol;
  logic e;

  always #5 sys_clk_in = ~sys_clk_in;

  clcc_top #(.NUM_SRC(64)) u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .cell_inputs_in(cell_inputs), .cell_output_out(cell_output_out), .cell_irq_flag_out(cell_irq_flag_out));
  clcc_src_model #(.NUM_SRC(64), .CODES(CODES)) u_src (.sys_clk_in(sys_clk_in), .data_in(data_r),
    .src_out(cell_inputs));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wr
  task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(name, reg_rdata_out, exp);
    @(posedge sys_clk_in);
  endtask : rdchk
  // gate g sees data g only, so gate levels equal the applied pattern XOR the gate invert bits
  task automatic settle(input logic [3:0] g);
    data_r <= g;
    repeat (4) @(posedge sys_clk_in);
  endtask : settle
  task automatic pins(input logic o, input logic f);
    @(negedge sys_clk_in);
    chk("cell output", {7'h00, cell_output_out}, {7'h00, o});
    chk("irq flag", {7'h00, cell_irq_flag_out}, {7'h00, f});
    @(posedge sys_clk_in);
  endtask : pins
  // disabling first clears stored state before the new function starts
  task automatic setmode(input logic [7:0] p, input logic [2:0] m);
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_POLARITY, p);
    wr(OFF_CONTROL, {5'h10, m});
    wr(OFF_IRQ_FLAG, 8'h01);
  endtask : setmode
  function automatic logic fexp(input logic [2:0] m, input logic [3:0] g);
    case (m)
      3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction : fexp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rdchk("control", OFF_CONTROL, CONTROL_RESET);
    for (int d = 0; d < 4; d++) begin
      wr(OFF_SELECT0 + 4'(d), 8'hC0 | {2'h0, CODES[6*d +: 6]});
      rdchk("select", OFF_SELECT0 + 4'(d), {2'h0, CODES[6*d +: 6]});
      wr(OFF_GATE_SEL0 + 4'(d), 8'h02 << (2 * d));
    end
    wr(OFF_POLARITY, 8'hFF);
    rdchk("polarity", OFF_POLARITY, 8'h8F);
    wr(4'hF, 8'hFF);
    rdchk("unmapped", 4'hF, 8'h00);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      pol = (p == 0) ? 8'h00 : 8'h85;
      for (int m = 0; m < 3; m++) begin
        setmode(pol, 3'(m));
        for (int g = 0; g < 16; g++) begin
          settle(4'(g));
          e = fexp(3'(m), 4'(g) ^ pol[3:0]) ^ pol[7];
          pins(e, 1'b0);
          rdchk("control mirror", OFF_CONTROL, {2'h2, e, 2'h0, 3'(m)});
        end
      end
    end
    $display("test combinational done");
    wr(OFF_CONTROL, 8'h02);
    pins(1'b0, 1'b0);
    wr(OFF_POLARITY, 8'h05);
    wr(OFF_CONTROL, 8'hE2);
    rdchk("status write", OFF_CONTROL, 8'h82);
    pins(1'b0, 1'b0);
    $display("test enable done");
    for (int i = 0; i < 28; i++) begin
      if (int'(SEQ[i][7:5]) != prev_m) setmode(8'h00, SEQ[i][7:5]);
      prev_m = int'(SEQ[i][7:5]);
      settle(SEQ[i][4:1]);
      pins(SEQ[i][0], 1'b0);
    end
    $display("test sequential done");
    setmode(8'h00, MODE_AND4);
    settle(4'h0);
    wr(OFF_CONTROL, 8'h92);
    settle(4'hF);
    pins(1'b1, 1'b1);
    wr(OFF_IRQ_FLAG, 8'h01);
    pins(1'b1, 1'b0);
    settle(4'h0);
    pins(1'b0, 1'b0);
    wr(OFF_CONTROL, 8'h8A);
    settle(4'hF);
    pins(1'b1, 1'b0);
    settle(4'h0);
    pins(1'b0, 1'b1);
    rdchk("flag register", OFF_IRQ_FLAG, 8'h01);
    // rising edge lands in the same cycle as the clear write; the flag must stay set
    wr(OFF_CONTROL, 8'h9A);
    data_r <= 4'hF;
    wr(OFF_IRQ_FLAG, 8'h01);
    settle(4'hF);
    pins(1'b1, 1'b1);
    $display("test edge flag done");
    wr(OFF_POLARITY, 8'h85);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rdchk("control", OFF_CONTROL, 8'h00);
    rdchk("polarity kept", OFF_POLARITY, 8'h05);
    rdchk("select kept", OFF_SELECT0 + 4'h3, 8'h3F);
    pins(1'b0, 1'b0);
    $display("test reset done");
    end_sim();
  end
endmodule : clcc_top_tb
`default_nettype wire
